/* dooc_pkg.sv */
// Purpose: Shared constants and carrier types for the digital output override block
// Assumes: Entries are addressed by a 16-bit index and an 8-bit subindex
// Notes:   Output level bits start at bit 16 of every 32-bit control word
package dooc_pkg;

   // Entry indices
   localparam logic [15:0] IDX_OUT_CTRL  = 16'h3250;
   localparam logic [15:0] IDX_ROUTING   = 16'h3252;

   // Subindices of the output control entry
   localparam logic [7:0]  SUB_COUNT     = 8'h00;
   localparam logic [7:0]  SUB_UNUSED    = 8'h01;
   localparam logic [7:0]  SUB_INVERT    = 8'h02;
   localparam logic [7:0]  SUB_FORCE_EN  = 8'h03;
   localparam logic [7:0]  SUB_FORCE_LVL = 8'h04;
   localparam logic [7:0]  SUB_APPLIED   = 8'h05;
   localparam logic [7:0]  SUB_SPARE1    = 8'h06;
   localparam logic [7:0]  SUB_SPARE2    = 8'h07;
   localparam logic [7:0]  SUB_ROUTE_ON  = 8'h08;
   localparam logic [7:0]  SUB_LED_MASK  = 8'h09;

   // Subindices of the routing entry; selector n sits at SUB_SEL_BASE + n
   localparam logic [7:0]  SUB_SEL_BASE  = 8'h01;

   // Reset values
   localparam logic [7:0]  CTRL_COUNT_RST = 8'h09;
   localparam logic [31:0] WORD_RST       = 32'h0000_0000;
   localparam logic [31:0] LED_MASK_RST   = 32'h0fff_ffff;
   localparam logic [15:0] SEL_BRAKE_RST  = 16'h1080;
   localparam logic [15:0] SEL_OUT1_RST   = 16'h0090;
   localparam logic [15:0] SEL_OUT2_RST   = 16'h0091;
   localparam logic [15:0] SEL_OTHER_RST  = 16'h0000;

   // Field positions
   localparam int          LVL_LSB       = 16;
   localparam int          ROUTE_ON_BIT  = 0;
   localparam int          LED_GREEN_BIT = 0;
   localparam int          LED_RED_BIT   = 1;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [15:0] index;
      logic [7:0]  sub;
      logic [31:0] wdata;
   } dooc_od_req_t;

   typedef struct packed {
      logic        valid;
      logic        err;
      logic [31:0] rdata;
   } dooc_od_rsp_t;

endpackage

/* dooc_out_ctrl.sv */
// Purpose: Digital output override, routing and indicator enable control
// Assumes: Requests, requested levels, route sources and blink sources share sys_clk_i
// Notes:   Output 0 is the brake, outputs 1 and 2 follow; level bit of output n is bit 16+n
// What this block does
// - Low sixteen bits of each control word are special functions, upper sixteen output levels.
// - A set inversion bit inverts the sense of its output.
// - A set force-enable bit drives the output from the force-value word.
// - The forced value passes through inversion: with inversion clear, zero gives low level and one high.
// - The applied output pattern is kept in the raw-value word for reading.
// - Routing-enable set to one makes each output follow its assigned source.
// - While routing is on, unused, inversion, force-enable and force-value entries are ignored.
// - A zero LED mask bit keeps that indicator dark.
// - Every output, brake included, has a routing selector naming its source.
// - After reset the selectors hold the default brake, first and second source codes.
`timescale 1ns/1ns
module dooc_out_ctrl
   import dooc_pkg::*;
#(
   parameter int NOUT  = 3,
   parameter int SRC_W = 8
) (
   // Clock and reset
   input  wire logic                  sys_clk_i,
   input  wire logic                  rst_n_i,
   // Object dictionary access
   input  wire dooc_od_req_t          od_req_i,
   output      dooc_od_rsp_t          od_rsp_o,
   // Level sources
   input  wire logic [31:0]           phys_out_req_i,
   input  wire logic [2**SRC_W-1:0]   route_src_i,
   input  wire logic                  run_blink_i,
   input  wire logic                  fault_blink_i,
   // Outputs
   output      logic [NOUT-1:0]       out_level_o,
   output      logic                  green_run_indicator_o,
   output      logic                  red_fault_indicator_o
);

   logic [31:0]           output_unused_word;
   logic [31:0]           output_invert_mask;
   logic [31:0]           output_force_mask;
   logic [31:0]           output_force_level;
   logic [31:0]           output_applied_pattern;
   logic [31:0]           output_routing_switch;
   logic [31:0]           indicator_led_mask;
   logic [15:0]           src_sel [NOUT];
   logic [NOUT-1:0]       next_level;
   logic [31:0]           next_applied;
   logic [31:0]           rd_word;
   logic                  rd_hit;
   dooc_od_rsp_t          next_rsp;

   function automatic logic [15:0] sel_reset(input int n);
      case (n)
         0:       sel_reset = SEL_BRAKE_RST;
         1:       sel_reset = SEL_OUT1_RST;
         2:       sel_reset = SEL_OUT2_RST;
         default: sel_reset = SEL_OTHER_RST;
      endcase
   endfunction

   // Decode
   wire   hit_ctrl  = (od_req_i.index == IDX_OUT_CTRL);
   wire   hit_rt    = (od_req_i.index == IDX_ROUTING);
   wire   wr_ctrl   = od_req_i.wr & hit_ctrl;
   wire   wr_rt     = od_req_i.wr & hit_rt;
   wire   route_on  = output_routing_switch[ROUTE_ON_BIT];
   // Override entries freeze while routed so a stray write cannot bite after routing ends
   wire   ovr_open  = ~route_on;
   wire   we_unused = wr_ctrl & (od_req_i.sub == SUB_UNUSED) & ovr_open;
   wire   we_invert = wr_ctrl & (od_req_i.sub == SUB_INVERT) & ovr_open;
   wire   we_fmask  = wr_ctrl & (od_req_i.sub == SUB_FORCE_EN) & ovr_open;
   wire   we_flevel = wr_ctrl & (od_req_i.sub == SUB_FORCE_LVL) & ovr_open;
   // Routing and LED entries stay writable while routed, or routing could never be left
   wire   we_route  = wr_ctrl & (od_req_i.sub == SUB_ROUTE_ON);
   wire   we_led    = wr_ctrl & (od_req_i.sub == SUB_LED_MASK);
   wire   sel_sub   = (od_req_i.sub >= SUB_SEL_BASE) &&
                      (od_req_i.sub < SUB_SEL_BASE + 8'(NOUT));
   wire   [7:0] sel_idx = od_req_i.sub - SUB_SEL_BASE;

   // Per-output level path and routing selector
   genvar gi;
   generate
      for (gi = 0; gi < NOUT; gi++) begin : g_out
         wire req_lvl  = phys_out_req_i[LVL_LSB+gi];
         wire forced   = output_force_mask[LVL_LSB+gi] ?
                         output_force_level[LVL_LSB+gi] : req_lvl;
         wire plain    = forced ^ output_invert_mask[LVL_LSB+gi];
         // Selector held locally so each register has a single writing process
         logic [15:0] sel_q;
         wire routed   = route_src_i[src_sel[gi][SRC_W-1:0]];
         assign next_level[gi] = route_on ? routed : plain;
         assign src_sel[gi]    = sel_q;

         always_ff @(posedge sys_clk_i) begin
            if (!rst_n_i) begin
               sel_q <= sel_reset(gi);
            end else if (wr_rt && (sel_idx == 8'(gi))) begin
               sel_q <= od_req_i.wdata[15:0];
            end
         end
      end
   endgenerate

   assign next_applied = {{(32-LVL_LSB-NOUT){1'b0}}, next_level, {LVL_LSB{1'b0}}};

   // Control words
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         output_unused_word    <= WORD_RST;
         output_invert_mask    <= WORD_RST;
         output_force_mask     <= WORD_RST;
         output_force_level    <= WORD_RST;
         output_routing_switch <= WORD_RST;
         indicator_led_mask    <= LED_MASK_RST;
      end else begin
         if (we_unused) output_unused_word <= od_req_i.wdata;
         if (we_invert) output_invert_mask <= od_req_i.wdata;
         if (we_fmask) output_force_mask <= od_req_i.wdata;
         if (we_flevel) output_force_level <= od_req_i.wdata;
         if (we_route) output_routing_switch <= od_req_i.wdata;
         if (we_led) indicator_led_mask <= od_req_i.wdata;
      end
   end

   // Applied pattern is refreshed every cycle, so a write to it has no lasting effect
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         output_applied_pattern <= WORD_RST;
         green_run_indicator_o  <= 1'b0;
         red_fault_indicator_o  <= 1'b0;
      end else begin
         output_applied_pattern <= next_applied;
         green_run_indicator_o  <= indicator_led_mask[LED_GREEN_BIT] & run_blink_i;
         red_fault_indicator_o  <= indicator_led_mask[LED_RED_BIT] & fault_blink_i;
      end
   end

   assign out_level_o = output_applied_pattern[LVL_LSB +: NOUT];

   // Read selection; spare entries read as zero
   always_comb begin
      rd_word = 32'h0000_0000;
      rd_hit  = 1'b1;
      if (hit_ctrl) begin
         unique case (od_req_i.sub)
            SUB_COUNT:     rd_word = {24'h00_0000, CTRL_COUNT_RST};
            SUB_UNUSED:    rd_word = output_unused_word;
            SUB_INVERT:    rd_word = output_invert_mask;
            SUB_FORCE_EN:  rd_word = output_force_mask;
            SUB_FORCE_LVL: rd_word = output_force_level;
            SUB_APPLIED:   rd_word = output_applied_pattern;
            SUB_SPARE1:    rd_word = 32'h0000_0000;
            SUB_SPARE2:    rd_word = 32'h0000_0000;
            SUB_ROUTE_ON:  rd_word = output_routing_switch;
            SUB_LED_MASK:  rd_word = indicator_led_mask;
            default:       rd_hit  = 1'b0;
         endcase
      end else if (hit_rt) begin
         if (od_req_i.sub == SUB_COUNT) begin
            rd_word = {24'h00_0000, 8'(NOUT)};
         end else if (sel_sub) begin
            rd_word = {16'h0000, src_sel[sel_idx[$clog2(NOUT+1)-1:0]]};
         end else begin
            rd_hit = 1'b0;
         end
      end else begin
         rd_hit = 1'b0;
      end
   end

   // Writes to counts are refused as errors; unknown entries answer error with zero data
   wire wr_ro = od_req_i.wr & (hit_ctrl | hit_rt) & (od_req_i.sub == SUB_COUNT);

   always_comb begin
      next_rsp.valid = od_req_i.rd | od_req_i.wr;
      next_rsp.err   = (od_req_i.rd | od_req_i.wr) & (~rd_hit | wr_ro);
      next_rsp.rdata = (od_req_i.rd & rd_hit) ? rd_word : 32'h0000_0000;
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         od_rsp_o <= '0;
      end else begin
         od_rsp_o <= next_rsp;
      end
   end

   // Checks
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);

   // Checks below name outputs 1 and 2 directly, so they need NOUT of at least 3
   wire [15:0] sel0_src = src_sel[0];
   wire [15:0] sel1_src = src_sel[1];
   wire [15:0] sel2_src = src_sel[2];

   force_drive_a: assert property (
      (!route_on && output_force_mask[LVL_LSB] && !we_route)
      |=> out_level_o[0] == ($past(output_force_level[LVL_LSB]) ^ $past(output_invert_mask[LVL_LSB])))
      else $error("forced output 0 level wrong");

   invert_sense_a: assert property (
      (!route_on && !output_force_mask[LVL_LSB])
      |=> out_level_o[0] == ($past(phys_out_req_i[LVL_LSB]) ^ $past(output_invert_mask[LVL_LSB])))
      else $error("unforced output 0 level wrong");

   routed_follow_a: assert property (
      route_on |=> out_level_o[0] == $past(route_src_i[sel0_src[SRC_W-1:0]]))
      else $error("routed output 0 does not follow its source");

   lock_hold_a: assert property (
      (route_on && od_req_i.wr && hit_ctrl && od_req_i.sub >= SUB_UNUSED && od_req_i.sub <= SUB_FORCE_LVL)
      |=> $stable(output_invert_mask) && $stable(output_force_mask) && $stable(output_force_level)
          && $stable(output_unused_word))
      else $error("override entry changed while routed");

   applied_read_a: assert property (
      (od_req_i.rd && hit_ctrl && od_req_i.sub == SUB_APPLIED)
      |=> od_rsp_o.valid && od_rsp_o.rdata == $past(output_applied_pattern))
      else $error("applied pattern read wrong");

   word_split_a: assert property (
      ##1 output_applied_pattern[LVL_LSB-1:0] == 16'h0000)
      else $error("level bits leaked into special function half");

   green_dark_a: assert property (
      !indicator_led_mask[LED_GREEN_BIT] |=> !green_run_indicator_o)
      else $error("green indicator lit while disabled");

   red_follow_a: assert property (
      indicator_led_mask[LED_RED_BIT] |=> red_fault_indicator_o == $past(fault_blink_i))
      else $error("red indicator not following fault blink");

   sel_reset_a: assert property (
      (!$past(rst_n_i) && rst_n_i)
      |-> src_sel[0] == SEL_BRAKE_RST && src_sel[1] == SEL_OUT1_RST && src_sel[2] == SEL_OUT2_RST)
      else $error("selector reset codes wrong");

   force_out1_a: assert property (
      (!route_on && output_force_mask[LVL_LSB+1])
      |=> out_level_o[1] == ($past(output_force_level[LVL_LSB+1]) ^ $past(output_invert_mask[LVL_LSB+1])))
      else $error("forced output 1 level wrong");

   invert_out2_a: assert property (
      (!route_on && !output_force_mask[LVL_LSB+2])
      |=> out_level_o[2] == ($past(phys_out_req_i[LVL_LSB+2]) ^ $past(output_invert_mask[LVL_LSB+2])))
      else $error("unforced output 2 level wrong");

   routed_out1_a: assert property (
      route_on
      |=> out_level_o[1] == $past(route_src_i[sel1_src[SRC_W-1:0]]))
      else $error("routed output 1 does not follow its source");

   routed_out2_a: assert property (
      route_on
      |=> out_level_o[2] == $past(route_src_i[sel2_src[SRC_W-1:0]]))
      else $error("routed output 2 does not follow its source");

   route_switch_a: assert property (
      we_route
      |=> route_on == $past(od_req_i.wdata[ROUTE_ON_BIT]))
      else $error("routing switch did not take the written bit");

   sel_write_a: assert property (
      (wr_rt && sel_idx == 8'h02)
      |=> sel2_src == $past(od_req_i.wdata[15:0]))
      else $error("output 2 selector write lost");

   invert_write_a: assert property (
      (!route_on && wr_ctrl && od_req_i.sub == SUB_INVERT)
      |=> output_invert_mask == $past(od_req_i.wdata))
      else $error("inversion write lost while unrouted");

   fmask_write_a: assert property (
      (!route_on && wr_ctrl && od_req_i.sub == SUB_FORCE_EN)
      |=> output_force_mask == $past(od_req_i.wdata))
      else $error("force enable write lost while unrouted");

   flevel_write_a: assert property (
      (!route_on && wr_ctrl && od_req_i.sub == SUB_FORCE_LVL)
      |=> output_force_level == $past(od_req_i.wdata))
      else $error("force value write lost while unrouted");

   green_follow_a: assert property (
      indicator_led_mask[LED_GREEN_BIT]
      |=> green_run_indicator_o == $past(run_blink_i))
      else $error("green indicator not following run blink");

   red_dark_a: assert property (
      !indicator_led_mask[LED_RED_BIT]
      |=> !red_fault_indicator_o)
      else $error("red indicator lit while disabled");

   routed_toggle_c: cover property (route_on ##1 $changed(out_level_o[0]));
   forced_invert_c: cover property (!route_on && output_force_mask[LVL_LSB] && output_force_level[LVL_LSB]
                                    && output_invert_mask[LVL_LSB] ##1 !out_level_o[0]);
   led_dark_c:      cover property (!indicator_led_mask[LED_RED_BIT] && fault_blink_i);
   locked_write_c:  cover property (route_on && we_route == 1'b0 && wr_ctrl && od_req_i.sub == SUB_INVERT);
   routed_sel_c:    cover property (route_on && wr_rt);

endmodule

/* dooc_far_model.sv */
// Purpose: Far-side model of the route signal sources and blink sources
// Assumes: Bench picks the hot route source and blink levels, model launches them on the falling edge
// Notes:   Only one route line is high, so a wrong selector shows at once
`timescale 1ns/1ns
module dooc_far_model (
   // Clock
   input  wire logic         sys_clk_i,
   // Bench control
   input  wire logic [7:0]   hot_src_i,
   input  wire logic [1:0]   blink_set_i,
   // Sources towards the block
   output      logic [255:0] route_src_o,
   output      logic         run_blink_o,
   output      logic         fault_blink_o
);
   initial begin
      route_src_o = '0;
      run_blink_o = 1'b0;
      fault_blink_o = 1'b0;
   end
   // One-hot source word, a selector names exactly one line
   always @(negedge sys_clk_i) begin
      route_src_o <= 256'h1 << hot_src_i;
      run_blink_o <= blink_set_i[0];
      fault_blink_o <= blink_set_i[1];
   end
endmodule

/* testbench.sv */
// Purpose: Self-checking bench for the digital output override block
// Assumes: Inputs change on the falling edge, outputs sampled mid-cycle
// Notes:   Waits on the response are bounded; a missing response ends the run
`timescale 1ns/1ns
module testbench;
   import dooc_pkg::*;
   logic         sys_clk_i = 1'b0;
   logic         rst_n_i   = 1'b0;
   dooc_od_req_t req       = '0;
   dooc_od_rsp_t od_rsp_o;
   dooc_od_rsp_t rsp;
   logic [31:0]  phys      = 32'h0;
   logic [7:0]   hot       = 8'h0;
   logic [1:0]   blink     = 2'b00;
   logic [255:0] route_src;
   logic         run_b;
   logic         fault_b;
   logic [2:0]   out_level_o;
   logic         green_o;
   logic         red_o;
   int           fail_count = 0;
   int           checked    = 0;
   always #50 sys_clk_i = ~sys_clk_i;
   dooc_far_model far (.sys_clk_i(sys_clk_i), .hot_src_i(hot), .blink_set_i(blink),
      .route_src_o(route_src), .run_blink_o(run_b), .fault_blink_o(fault_b));
   dooc_out_ctrl uut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .od_req_i(req), .od_rsp_o(od_rsp_o),
      .phys_out_req_i(phys), .route_src_i(route_src), .run_blink_i(run_b), .fault_blink_i(fault_b),
      .out_level_o(out_level_o), .green_run_indicator_o(green_o), .red_fault_indicator_o(red_o));
   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // One request, answer taken mid-cycle after the taking edge
   task automatic od(input logic w, input logic [15:0] ix, input logic [7:0] sb, input logic [31:0] d);
      int n = 0;
      @(negedge sys_clk_i);
      req = '{wr: w, rd: !w, index: ix, sub: sb, wdata: d};
      @(negedge sys_clk_i);
      req.wr = 1'b0;
      req.rd = 1'b0;
      while (od_rsp_o.valid !== 1'b1 && n < 4) begin
         @(negedge sys_clk_i);
         n++;
      end
      if (n == 4) begin
         fail_count++;
         tally_and_finish();
      end
      rsp = od_rsp_o;
   endtask
   task automatic rd(input string name, input logic [15:0] ix, input logic [7:0] sb, input logic [31:0] exp);
      od(1'b0, ix, sb, 32'h0);
      chk(name, rsp.rdata, exp);
   endtask
   // Register changes reach the pins after two edges; three gives margin for the model stage
   task automatic out_is(input logic [2:0] exp);
      repeat (3) @(negedge sys_clk_i);
      chk("out_level", {29'h0, out_level_o}, {29'h0, exp});
   endtask
   task automatic t_reset();
      rd("count", IDX_OUT_CTRL, SUB_COUNT, 32'h0000_0009);
      rd("unused", IDX_OUT_CTRL, SUB_UNUSED, 32'h0);
      rd("invert", IDX_OUT_CTRL, SUB_INVERT, 32'h0);
      rd("force_en", IDX_OUT_CTRL, SUB_FORCE_EN, 32'h0);
      rd("force_lvl", IDX_OUT_CTRL, SUB_FORCE_LVL, 32'h0);
      rd("route_on", IDX_OUT_CTRL, SUB_ROUTE_ON, 32'h0);
      rd("led_mask", IDX_OUT_CTRL, SUB_LED_MASK, 32'h0fff_ffff);
      rd("sel_count", IDX_ROUTING, 8'h00, 32'h0000_0003);
      rd("sel_brake", IDX_ROUTING, 8'h01, 32'h0000_1080);
      rd("sel_out1", IDX_ROUTING, 8'h02, 32'h0000_0090);
      rd("sel_out2", IDX_ROUTING, 8'h03, 32'h0000_0091);
   endtask
   task automatic t_levels();
      phys = 32'h0007_ffff;
      out_is(3'b111);
      od(1'b1, IDX_OUT_CTRL, SUB_INVERT, 32'h0001_ffff);
      out_is(3'b110);
      od(1'b1, IDX_OUT_CTRL, SUB_FORCE_EN, 32'h0007_0000);
      od(1'b1, IDX_OUT_CTRL, SUB_FORCE_LVL, 32'h0003_0000);
      out_is(3'b010);
      rd("applied", IDX_OUT_CTRL, SUB_APPLIED, 32'h0002_0000);
      od(1'b1, IDX_OUT_CTRL, SUB_APPLIED, 32'hffff_ffff);
      rd("applied_wr", IDX_OUT_CTRL, SUB_APPLIED, 32'h0002_0000);
   endtask
   task automatic t_routing();
      hot = 8'h90;
      od(1'b1, IDX_OUT_CTRL, SUB_ROUTE_ON, 32'h0000_0001);
      out_is(3'b010);
      hot = 8'h80;
      out_is(3'b001);
      od(1'b1, IDX_ROUTING, 8'h03, 32'hffff_1042);
      rd("sel_out2", IDX_ROUTING, 8'h03, 32'h0000_1042);
      hot = 8'h42;
      out_is(3'b100);
      od(1'b1, IDX_OUT_CTRL, SUB_INVERT, 32'h0);
      od(1'b1, IDX_OUT_CTRL, SUB_UNUSED, 32'h0000_0005);
      od(1'b1, IDX_OUT_CTRL, SUB_FORCE_EN, 32'h0);
      chk("lock_err", {31'h0, rsp.err}, 32'h0);
      rd("lock_inv", IDX_OUT_CTRL, SUB_INVERT, 32'h0001_ffff);
      rd("lock_unused", IDX_OUT_CTRL, SUB_UNUSED, 32'h0);
      rd("lock_force", IDX_OUT_CTRL, SUB_FORCE_EN, 32'h0007_0000);
      od(1'b1, IDX_OUT_CTRL, SUB_ROUTE_ON, 32'h0);
      out_is(3'b010);
   endtask
   task automatic t_leds();
      logic [31:0] masks [4] = '{32'h0, 32'h1, 32'h2, 32'h3};
      blink = 2'b11;
      foreach (masks[i]) begin
         od(1'b1, IDX_OUT_CTRL, SUB_LED_MASK, masks[i]);
         repeat (2) @(negedge sys_clk_i);
         chk("green", {31'h0, green_o}, {31'h0, masks[i][0]});
         chk("red", {31'h0, red_o}, {31'h0, masks[i][1]});
      end
      blink = 2'b00;
      repeat (3) @(negedge sys_clk_i);
      chk("dark", {30'h0, green_o, red_o}, 32'h0);
   endtask
   task automatic t_refuse();
      od(1'b1, IDX_OUT_CTRL, SUB_COUNT, 32'h0000_0055);
      chk("err_count", {31'h0, rsp.err}, 32'h1);
      rd("count_kept", IDX_OUT_CTRL, SUB_COUNT, 32'h0000_0009);
      od(1'b1, IDX_OUT_CTRL, SUB_SPARE1, 32'hffff_ffff);
      rd("spare1", IDX_OUT_CTRL, SUB_SPARE1, 32'h0);
      rd("unmapped", 16'h3251, 8'h01, 32'h0);
      chk("err_unmap", {31'h0, rsp.err}, 32'h1);
   endtask
   initial begin
      repeat (4) @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      rst_n_i = 1'b1;
      t_reset();
      t_levels();
      t_routing();
      t_leds();
      t_refuse();
      tally_and_finish();
   end
endmodule
